// ---- shared/dma_defines.vh ----
// constants for the two-channel dma request and priority logic
// Contract
// - sense select 0: level request; polarity 0 active-low, 1 active-high.
// - sense select 1: edge request; polarity 0 falling, 1 rising edge.
// - any requester may raise a channel request, not just its endpoints.
// - with auto-request off, source 01 is serial rx, 10 is serial tx.
// - start only with channel and master enabled, no end, nmi or error flag.
// - serial request cleared on first unit (cycle-steal) or last (burst).
// - simultaneous requests arbitrated fixed or round-robin by priority mode.
// - fixed priority: channel 0 beats channel 1.
// - fixed cycle-steal with both requesting: alternate 1 and 0 after 0.
// - round-robin: finishing channel becomes lower priority.
// - round-robin starts after reset with channel 0 higher.
// - round-robin: finishing lower channel leaves order unchanged.
// - ack device pairs only with memory or mapped device, single mode.
// - on-chip endpoint is accessed with its own permitted access size.
// - single mode: one bus cycle, ack out, other endpoint addressed.
// - address mode set: single; acknowledge mode 0 mem->dev, 1 dev->mem.
`ifndef DMA_DEFINES_VH
`define DMA_DEFINES_VH

`define DMA_DATA_W 32
`define DMA_FIFO_DEPTH 16

// endpoint kinds
`define KIND_MEM 2'h0
`define KIND_MAP 2'h1
`define KIND_ACK 2'h2
`define KIND_CHIP 2'h3

// request source codes {hi, lo}
`define SRC_EXT 2'h0
`define SRC_RX 2'h1
`define SRC_TX 2'h2

// engine states
`define ST_IDLE 2'h0
`define ST_READ 2'h1
`define ST_WRITE 2'h2
`define ST_SINGLE 2'h3

// round-robin high channel after reset
`define PRIO_RESET 1'b0

`endif

// ---- core/dma_unit_fifo.v ----
// parameterised synchronous fifo holding words between read and write cycles
`timescale 1ns/100ps
module dma_unit_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 16
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  localparam AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;

  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem[rd_ptr];

  // storage has no reset; only the pointers and count need a defined value
  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
                  wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
                  rd_ptr + 1'b1;
      end
      if (push & ~pop) begin
        count <= count + 1'b1;
      end else if (pop & ~push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // dma_unit_fifo

// ---- core/dma_request_and_priority_logic.v ----
// two-channel dma request sensing, arbitration and transfer sequencing
`timescale 1ns/100ps
`include "dma_defines.vh"
module dma_request_and_priority_logic #(
  parameter DATA_W = `DMA_DATA_W,
  parameter FIFO_DEPTH = `DMA_FIFO_DEPTH
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // external request and acknowledge pins, one per channel
  input wire [1:0] dma_request_in,
  output wire [1:0] dma_acknowledge_out,
  // on-chip serial requests and their automatic clears
  input wire serial_rx_full_request,
  input wire serial_tx_empty_request,
  output reg serial_rx_clear,
  output reg serial_tx_clear,
  // global operation controls and flags
  input wire master_enable,
  input wire nmi_abort_flag,
  input wire address_error_flag,
  input wire priority_mode_select,
  // per-channel controls, bit n for channel n
  input wire [1:0] channel_enable,
  input wire [1:0] transfer_end_flag,
  input wire [1:0] auto_request_select,
  input wire [1:0] request_source_select_hi,
  input wire [1:0] request_source_select_lo,
  input wire [1:0] request_sense_select,
  input wire [1:0] request_polarity_select,
  input wire [1:0] burst_mode_select,
  input wire [1:0] address_mode_select,
  input wire [1:0] acknowledge_mode_select,
  input wire [1:0] final_unit,
  // per-channel endpoint kinds and sizes, bits [2n+1:2n] for channel n
  input wire [3:0] src_kind,
  input wire [3:0] dst_kind,
  input wire [3:0] unit_size,
  input wire [3:0] periph_size,
  // status
  output wire [1:0] config_error,
  output wire [1:0] pending_request,
  output reg high_priority_channel,
  // bus cycle request and answer
  output wire bus_req,
  output wire bus_write,
  output wire bus_addr_dst,
  output wire bus_channel,
  output wire [1:0] bus_size,
  output wire bus_hold,
  input wire bus_ack,
  input wire [DATA_W-1:0] bus_rdata,
  output wire [DATA_W-1:0] bus_wdata,
  // unit completion
  output reg unit_done,
  output reg done_channel
);
  reg [1:0] state;
  reg [1:0] next_state;
  reg cur_ch;
  reg next_ch;
  reg start;
  reg winner;
  reg last_ch;
  reg last_valid;
  reg [1:0] req_sync1;
  reg [1:0] req_sync2;
  reg [1:0] req_prev;
  reg [2:0] warm;
  wire [1:0] chan_ok;
  wire [1:0] legal;
  wire [1:0] chan_req;
  wire [1:0] eligible;
  wire [1:0] edge_pending;
  wire [1:0] cur_sk;
  wire [1:0] cur_dk;
  wire [1:0] cur_kind;
  wire cur_single;
  wire cur_am;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire fifo_push;
  wire fifo_pop;
  wire finish;
  wire abort;

  // request pins come from outside; two flops before anything looks at them
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req_sync1 <= 2'h0;
      req_sync2 <= 2'h0;
      req_prev <= 2'h0;
      warm <= 3'h0;
    end else begin
      req_sync1 <= dma_request_in;
      req_sync2 <= req_sync1;
      req_prev <= req_sync2;
      warm <= {warm[1:0], 1'b1};
    end
  end

  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_ch
      wire [1:0] sk;
      wire [1:0] dk;
      wire [1:0] rs;
      wire rise;
      wire fall;
      wire edge_hit;
      wire level_hit;
      wire ext_req;
      wire granted;
      wire single_ok;
      wire dual_ok;
      reg pend;

      assign sk = src_kind[2*i+1:2*i];
      assign dk = dst_kind[2*i+1:2*i];
      assign rs = {request_source_select_hi[i],
                   request_source_select_lo[i]};
      // edges ignored until the synchroniser and history hold real samples
      assign rise = warm[2] & req_sync2[i] & ~req_prev[i];
      assign fall = warm[2] & ~req_sync2[i] & req_prev[i];
      assign edge_hit = request_polarity_select[i] ? rise : fall;
      assign level_hit = request_polarity_select[i] ? req_sync2[i] :
                         ~req_sync2[i];
      assign granted = start & (next_ch == i);

      // a new edge in the grant cycle survives the clear
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          pend <= 1'b0;
        end else if (~request_sense_select[i]) begin
          pend <= 1'b0;
        end else if (edge_hit) begin
          pend <= 1'b1;
        end else if (granted) begin
          pend <= 1'b0;
        end
      end
      assign edge_pending[i] = pend;

      // the pin is taken from any requester, endpoints are not consulted
      assign ext_req = request_sense_select[i] ? edge_pending[i] :
                       level_hit;

      // the serial module drops its request only one cycle after the
      // clear, so the clear cycle masks it to stop a second unit
      assign chan_req[i] = auto_request_select[i] ? 1'b1 :
        (rs == `SRC_EXT) ? ext_req :
        (rs == `SRC_RX) ? serial_rx_full_request & ~serial_rx_clear :
        (rs == `SRC_TX) ? serial_tx_empty_request & ~serial_tx_clear :
        1'b0;

      assign chan_ok[i] = channel_enable[i] & master_enable &
                          ~transfer_end_flag[i] & ~nmi_abort_flag &
                          ~address_error_flag;

      // acknowledge device only against memory or a mapped device
      assign single_ok = acknowledge_mode_select[i] ?
        (sk == `KIND_ACK) & ((dk == `KIND_MEM) | (dk == `KIND_MAP)) :
        (dk == `KIND_ACK) & ((sk == `KIND_MEM) | (sk == `KIND_MAP));
      assign dual_ok = (sk != `KIND_ACK) & (dk != `KIND_ACK);
      assign legal[i] = address_mode_select[i] ? single_ok :
                        dual_ok;
      assign config_error[i] = ~legal[i];
      assign eligible[i] = chan_req[i] & chan_ok[i] & legal[i];
    end
  endgenerate

  assign pending_request = chan_req;

  // channel choice when both want the bus
  always @* begin
    winner = 1'b0;
    if (eligible == 2'h3) begin
      if (priority_mode_select) begin
        winner = high_priority_channel;
      end else if (~burst_mode_select[0] & last_valid & ~last_ch) begin
        winner = 1'b1;
      end else begin
        winner = 1'b0;
      end
    end else begin
      winner = eligible[1];
    end
  end

  assign cur_single = address_mode_select[cur_ch];
  assign cur_am = acknowledge_mode_select[cur_ch];
  // disabling a channel mid-unit only stops it before data has moved
  assign abort = ~chan_ok[cur_ch];

  always @* begin
    next_state = state;
    next_ch = cur_ch;
    start = 1'b0;
    case (state)
      `ST_IDLE: begin
        if (|eligible) begin
          if (address_mode_select[winner]) begin
            next_ch = winner;
            start = 1'b1;
            next_state = `ST_SINGLE;
          end else if (fifo_in_ready) begin
            // a full buffer holds off the next read cycle
            next_ch = winner;
            start = 1'b1;
            next_state = `ST_READ;
          end
        end
      end
      `ST_READ: begin
        if (abort) begin
          next_state = `ST_IDLE;
        end else if (bus_ack) begin
          next_state = `ST_WRITE;
        end
      end
      `ST_WRITE: begin
        if (bus_ack & fifo_out_valid) begin
          next_state = `ST_IDLE;
        end
      end
      `ST_SINGLE: begin
        if (abort) begin
          next_state = `ST_IDLE;
        end else if (bus_ack) begin
          next_state = `ST_IDLE;
        end
      end
      default: begin
        next_state = `ST_IDLE;
      end
    endcase
  end

  assign finish = ((state == `ST_WRITE) & bus_ack & fifo_out_valid) |
                  ((state == `ST_SINGLE) & bus_ack & ~abort);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= `ST_IDLE;
      cur_ch <= 1'b0;
      last_ch <= 1'b0;
      last_valid <= 1'b0;
      high_priority_channel <= `PRIO_RESET;
      unit_done <= 1'b0;
      done_channel <= 1'b0;
      serial_rx_clear <= 1'b0;
      serial_tx_clear <= 1'b0;
    end else begin
      state <= next_state;
      cur_ch <= next_ch;
      unit_done <= finish;
      serial_rx_clear <= 1'b0;
      serial_tx_clear <= 1'b0;
      if (finish) begin
        done_channel <= cur_ch;
        last_ch <= cur_ch;
        last_valid <= 1'b1;
        // finished channel drops to low; already low keeps the order
        if (priority_mode_select) begin
          high_priority_channel <= ~cur_ch;
        end
        if (~auto_request_select[cur_ch] &
            (~burst_mode_select[cur_ch] | final_unit[cur_ch])) begin
          serial_rx_clear <= ({request_source_select_hi[cur_ch],
            request_source_select_lo[cur_ch]} == `SRC_RX);
          serial_tx_clear <= ({request_source_select_hi[cur_ch],
            request_source_select_lo[cur_ch]} == `SRC_TX);
        end
      end
      if (~|eligible & (state == `ST_IDLE)) begin
        last_valid <= 1'b0;
      end
    end
  end

  // bus cycle description
  assign bus_req = (state == `ST_READ) | (state == `ST_SINGLE) |
                   ((state == `ST_WRITE) & fifo_out_valid);
  assign bus_channel = cur_ch;
  assign bus_write = (state == `ST_WRITE) |
                     ((state == `ST_SINGLE) & cur_am);
  // single mode addresses the memory end, the device only sees ack
  assign bus_addr_dst = (state == `ST_WRITE) |
                        ((state == `ST_SINGLE) & cur_am);
  assign dma_acknowledge_out[0] = ~cur_ch & (
    (state == `ST_SINGLE) |
    ((state == `ST_READ) & ~cur_am) |
    ((state == `ST_WRITE) & cur_am & fifo_out_valid));
  assign dma_acknowledge_out[1] = cur_ch & (
    (state == `ST_SINGLE) |
    ((state == `ST_READ) & ~cur_am) |
    ((state == `ST_WRITE) & cur_am & fifo_out_valid));

  assign cur_sk = cur_ch ? src_kind[3:2] : src_kind[1:0];
  assign cur_dk = cur_ch ? dst_kind[3:2] : dst_kind[1:0];
  assign cur_kind = (state == `ST_WRITE) ? cur_dk : cur_sk;
  assign bus_size = (cur_kind == `KIND_CHIP) ?
    (cur_ch ? periph_size[3:2] : periph_size[1:0]) :
    (cur_ch ? unit_size[3:2] : unit_size[1:0]);

  // burst keeps the bus while the channel still asks and has more units
  assign bus_hold = burst_mode_select[cur_ch] & eligible[cur_ch] &
                    ~final_unit[cur_ch];

  assign fifo_push = (state == `ST_READ) & bus_ack & ~abort;
  assign fifo_pop = (state == `ST_WRITE) & bus_ack;

  dma_unit_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .in_data(bus_rdata),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(bus_wdata)
  );
endmodule // dma_request_and_priority_logic

// ---- tb/bus_partner.sv ----
// bus responder standing in for memory and the acknowledged devices
`timescale 1ns/100ps
module bus_partner (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // cycle from the engine and wait length
  input wire bus_req,
  input wire [2:0] stall,
  // answer
  output reg bus_ack,
  output reg [31:0] bus_rdata
);
  reg [2:0] cnt;
  reg [31:0] word;
  wire go = bus_req && !bus_ack && cnt >= stall;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_ack <= 1'b0;
      cnt <= 3'h0;
      word <= 32'hC0DE0000;
      bus_rdata <= 32'h0;
    end else begin
      bus_ack <= go;
      cnt <= (bus_req && !bus_ack) ? cnt + 3'h1 : 3'h0;
      // data only valid with ack; otherwise a flipping pattern
      bus_rdata <= go ? word : ~word;
      if (bus_ack) word <= word + 32'h1;
    end
  end
endmodule // bus_partner

// ---- tb/dma_monitor.sv ----
// concurrent checks on the dma request and priority ports
`timescale 1ns/100ps
module dma_monitor (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // controls
  input wire master_enable,
  input wire nmi_abort_flag,
  input wire address_error_flag,
  input wire priority_mode_select,
  input wire [1:0] channel_enable,
  input wire [1:0] transfer_end_flag,
  input wire [1:0] address_mode_select,
  input wire [1:0] acknowledge_mode_select,
  input wire [1:0] request_source_select_hi,
  input wire [1:0] request_source_select_lo,
  // outputs watched
  input wire [1:0] dma_acknowledge_out,
  input wire [1:0] config_error,
  input wire high_priority_channel,
  input wire bus_req,
  input wire bus_write,
  input wire bus_channel,
  input wire bus_ack,
  input wire unit_done,
  input wire done_channel,
  input wire serial_rx_clear,
  input wire serial_tx_clear
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire ok_g = master_enable && !nmi_abort_flag && !address_error_flag;
  wire [1:0] ok = {2{ok_g}} & channel_enable & ~transfer_end_flag &
    ~config_error;
  reg [1:0] ok_d;
  // eligibility one edge back, as the idle state saw it
  always @(posedge clk) ok_d <= ok;
  property p_single;
    bus_req && address_mode_select[bus_channel] |->
      dma_acknowledge_out[bus_channel] &&
      bus_write == acknowledge_mode_select[bus_channel];
  endproperty
  a_single: assert property (p_single)
    else $error("single cycle without ack or wrong direction");
  property p_start;
    $rose(bus_req) |-> ok_d[bus_channel];
  endproperty
  a_start: assert property (p_start)
    else $error("unit started on an ineligible channel");
  property p_done;
    unit_done |-> $past(bus_ack);
  endproperty
  a_done: assert property (p_done)
    else $error("unit done without a bus answer");
  property p_hold;
    bus_req && !bus_ack |=> bus_req && $stable(bus_channel);
  endproperty
  a_hold: assert property (p_hold)
    else $error("bus request dropped before its answer");
  property p_rx;
    serial_rx_clear |-> unit_done &&
      !request_source_select_hi[done_channel] &&
      request_source_select_lo[done_channel];
  endproperty
  a_rx: assert property (p_rx)
    else $error("rx clear outside a finished unit");
  property p_tx;
    serial_tx_clear |-> unit_done &&
      request_source_select_hi[done_channel] &&
      !request_source_select_lo[done_channel];
  endproperty
  a_tx: assert property (p_tx)
    else $error("tx clear outside a finished unit");
  property p_rr;
    unit_done && priority_mode_select |->
      ##[0:1] high_priority_channel != done_channel;
  endproperty
  a_rr: assert property (p_rr)
    else $error("finished channel kept the high priority");
  property p_rst;
    $rose(rst_n) |-> !high_priority_channel;
  endproperty
  a_rst: assert property (p_rst)
    else $error("channel 1 high after reset");
  c_done1: cover property (unit_done && done_channel);
  c_rx: cover property (serial_rx_clear);
  c_single: cover property (bus_req && address_mode_select[bus_channel]);
endmodule // dma_monitor
bind dma_request_and_priority_logic dma_monitor mon (.*);

// ---- tb/tb.sv ----
// self-checking bench for the dma request and priority logic
`timescale 1ns/100ps
module tb;
  reg clk, rst_n, rxr, txr, me, nmi, aerr, prm, c;
  reg [1:0] req, ce, te, ar, rsh, rsl, ss, ps, bm, am, akm, fu;
  reg [3:0] sk, dk;
  reg [2:0] stall;
  wire [1:0] ack, cerr, pend, bsz;
  wire rxc, txc, hp, breq, bw, bad, bch, bh, back, ud, dc;
  wire [31:0] rd, wd;
  reg [31:0] lr, lw;
  reg lwr, lad, lhd;
  reg [1:0] lsz;
  reg [1:0] q[$];
  integer n_errors = 0;
  integer num_checks = 0;
  dma_request_and_priority_logic dut (.clk(clk), .rst_n(rst_n),
    .dma_request_in(req), .dma_acknowledge_out(ack),
    .serial_rx_full_request(rxr), .serial_tx_empty_request(txr),
    .serial_rx_clear(rxc), .serial_tx_clear(txc), .master_enable(me),
    .nmi_abort_flag(nmi), .address_error_flag(aerr),
    .priority_mode_select(prm), .channel_enable(ce),
    .transfer_end_flag(te), .auto_request_select(ar),
    .request_source_select_hi(rsh), .request_source_select_lo(rsl),
    .request_sense_select(ss), .request_polarity_select(ps),
    .burst_mode_select(bm), .address_mode_select(am),
    .acknowledge_mode_select(akm), .final_unit(fu), .src_kind(sk),
    .dst_kind(dk), .unit_size(4'hA), .periph_size(4'h5),
    .config_error(cerr), .pending_request(pend),
    .high_priority_channel(hp), .bus_req(breq), .bus_write(bw),
    .bus_addr_dst(bad), .bus_channel(bch), .bus_size(bsz),
    .bus_hold(bh), .bus_ack(back), .bus_rdata(rd), .bus_wdata(wd),
    .unit_done(ud), .done_channel(dc));
  bus_partner mem (.clk(clk), .rst_n(rst_n), .bus_req(breq),
    .stall(stall), .bus_ack(back), .bus_rdata(rd));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (ud) q.push_back({1'b0, dc});
    if (back && breq && !bw) lr <= rd;
    if (back && breq) lwr <= bw;
    if (back && breq) lad <= bad;
    if (back && breq) lhd <= bh;
    if (back && breq && !bw) lsz <= bsz;
    if (back && breq && bw) lw <= wd;
    // serial module drops its request when cleared
    if (rxc) rxr <= 1'b0;
    if (txc) txr <= 1'b0;
  end
  task chk(input [31:0] g, input [31:0] e);
    begin
      num_checks = num_checks + 1;
      if (g !== e) begin
        n_errors = n_errors + 1;
        $display("CHECK FAILED %0t: got %0h want %0h", $time, g, e);
      end
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task wdone(input integer n);
    integer i;
    begin
      for (i = 0; i < 300 && q.size() < n; i = i + 1) cyc(1);
      chk(q.size() >= n, 1);
    end
  endtask
  task fin(input [63:0] nm);
    begin
      cyc(14);
      $display("%0s done", nm);
    end
  endtask
  task base;
    begin
      me <= 1'b1; ce <= 2'b11; te <= 2'b00; nmi <= 1'b0; aerr <= 1'b0;
      prm <= 1'b0; ar <= 2'b00; rsh <= 2'b00; rsl <= 2'b00;
      ss <= 2'b00; ps <= 2'b11; bm <= 2'b00; am <= 2'b00; akm <= 2'b00;
      sk <= 4'h0; dk <= 4'h0; stall <= 3'h0; q.delete();
    end
  endtask
  task t_single;
    begin
      // ch1 held off until its pin has crossed the synchroniser
      base; ps <= 2'b01; am <= 2'b01; akm <= 2'b01; sk <= 4'h2;
      ce <= 2'b01; stall <= 3'h3; req <= 2'b10;
      cyc(4);
      ce <= 2'b11;
      cyc(10);
      chk(q.size(), 0);
      req <= 2'b11;
      wdone(1);
      req <= 2'b10;
      chk(q[0], 0);
      chk(lwr, 1);
      chk(lad, 1);
      fin("single");
    end
  endtask
  task t_edge;
    begin
      base; ss <= 2'b10; ps <= 2'b01; req <= 2'b10;
      cyc(4);
      req <= 2'b00;
      wdone(1);
      req <= 2'b10;
      cyc(14);
      chk(q.size(), 1);
      chk(q[0], 1);
      chk(lw, lr);
      req <= 2'b00;
      fin("edge");
    end
  endtask
  task t_serial;
    begin
      // rx reads the chip source, tx writes the chip destination
      base; rsl <= 2'b01; rsh <= 2'b10; sk <= 4'h3; dk <= 4'hC;
      ss <= 2'b11; ps <= 2'b00; stall <= 3'h2; rxr <= 1'b1;
      wdone(1);
      chk(q[0], 0);
      chk(lsz, 2'h1);
      cyc(1);
      chk(rxr, 0);
      txr <= 1'b1;
      wdone(2);
      chk(q[1], 1);
      cyc(1);
      chk(txr, 0);
      fin("serial");
    end
  endtask
  task t_block;
    integer i;
    begin
      for (i = 0; i < 5; i = i + 1) begin
        base; me <= (i != 0); ce <= (i == 1) ? 2'b10 : 2'b11;
        te <= {1'b0, i == 2}; nmi <= (i == 3); aerr <= (i == 4);
        req <= 2'b01;
        cyc(12);
        req <= 2'b00;
        chk(q.size(), 0);
        cyc(4);
      end
      base; sk <= 4'hE; dk <= 4'hA; req <= 2'b11;
      cyc(12);
      chk(cerr, 2'b11);
      chk(pend, 2'b11);
      chk(q.size(), 0);
      req <= 2'b00;
      fin("blocked");
    end
  endtask
  task t_fixed(input [1:0] burst);
    begin
      base; bm <= burst; stall <= 3'h1; req <= 2'b11;
      wdone(3);
      chk(lhd, burst[0]);
      req <= 2'b00;
      chk(q[0], 0);
      chk(q[1], !burst[0]);
      chk(q[2], 0);
      fin("fixed");
    end
  endtask
  task t_rr;
    begin
      base; prm <= 1'b1; req <= 2'b11;
      wdone(3);
      req <= 2'b00;
      chk(q[0], 0);
      chk(q[1], 1);
      chk(q[2], 0);
      fin("rr pair");
      c = q[q.size() - 1];
      chk(hp, !c);
      q.delete();
      req <= 2'b01 << c;
      wdone(1);
      req <= 2'b00;
      fin("rr lower");
      chk(hp, !c);
    end
  endtask
  task results;
    begin
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  initial begin
    rst_n = 1'b0; req = 2'b00; rxr = 1'b0; txr = 1'b0; fu = 2'b00;
    c = 1'b0; base;
    cyc(20);
    rst_n <= 1'b1;
    cyc(4);
    t_rr;
    t_single;
    t_edge;
    t_serial;
    t_block;
    t_fixed(2'b00);
    t_fixed(2'b01);
    results;
  end
  initial begin
    cyc(20000);
    n_errors = n_errors + 1;
    results;
  end
endmodule // tb
